// >>> core/sram_host_pkg.sv
package sram_host_pkg;
    // bus geometry
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    // clock rate
    localparam int CLK_PERIOD_PS = 5000;
    // timing figures in ns, fastest grade
    localparam int WRITE_CYCLE_MIN_NS = 100;
    localparam int WRITE_PULSE_MIN_NS = 60;
    localparam int SELECT_TO_WRITE_FINISH_NS = 80;
    localparam int DATA_SETUP_BEFORE_FINISH_NS = 40;
    localparam int ADDRESS_HOLD_AFTER_STROBE_FINISH_NS = 5;
    localparam int READ_CYCLE_MIN_NS = 100;
    localparam int ADDRESS_ACCESS_DELAY_NS = 100;
    localparam int FLOAT_MAX_NS = 35;
    // least times round up to whole cycles
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int SETUP_CYC = 1;
    localparam int PULSE_CYC = ns_to_cyc(SELECT_TO_WRITE_FINISH_NS);
    localparam int HOLD_CYC = ns_to_cyc(ADDRESS_HOLD_AFTER_STROBE_FINISH_NS);
    // two synchroniser flops plus one cycle of margin, so capture never lands on the access limit itself
    localparam int ACCESS_CYC = ns_to_cyc(ADDRESS_ACCESS_DELAY_NS) + 3;
    localparam int FLOAT_CYC = ns_to_cyc(FLOAT_MAX_NS);
    localparam int RECOVERY_CYC = ns_to_cyc(READ_CYCLE_MIN_NS);
    localparam int CNT_W = 8;
    // memory pin group
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic primary_select_n;
        logic secondary_select;
        logic output_gate_n;
        logic write_strobe_n;
    } pins_t;
    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE
    } op_t;
endpackage

// >>> core/sram_host.sv
// Behaviour
// - write only while primary low, secondary high and strobe low together
// - write interval spans last qualifying edge to first removing edge
// - host keeps write interval at least the grade minimum
// - both selects active long enough before write finishes
// - address stable before write start and long before finish
// - address held after write finishes
// - write data valid well before finish, may drop at finish
// - consecutive write starts spaced by write cycle minimum
// - host never drives data lines while memory drives them
// - deselect before supply lowers for retention
// - wait one read cycle after supply returns
// - in retention, secondary select held at a firm level
`timescale 1ns/1ps
`default_nettype none
module sram_host #(
    parameter int SETUP_CYCLES = sram_host_pkg::SETUP_CYC,
    parameter int PULSE_CYCLES = sram_host_pkg::PULSE_CYC,
    parameter int HOLD_CYCLES = sram_host_pkg::HOLD_CYC,
    parameter int ACCESS_CYCLES = sram_host_pkg::ACCESS_CYC,
    parameter int FLOAT_CYCLES = sram_host_pkg::FLOAT_CYC,
    parameter int RECOVERY_CYCLES = sram_host_pkg::RECOVERY_CYC
) (
    input wire logic ref_clk_in, // system clock
    input wire logic reset_n_in, // async reset, active low
    input wire logic req_valid_in, // request strobe
    input wire logic req_write_in, // 1 write, 0 read
    input wire logic [sram_host_pkg::ADDR_W-1:0] req_addr_in, // word address
    input wire logic [sram_host_pkg::DATA_W-1:0] req_wdata_in, // write data
    input wire logic retain_in, // hold memory in retention
    output logic req_ready_out, // idle, request accepted
    output logic rsp_valid_out, // one-cycle done pulse
    output logic [sram_host_pkg::DATA_W-1:0] rsp_rdata_out, // read data
    output logic retained_out, // retention entered
    output logic [sram_host_pkg::ADDR_W-1:0] mem_addr_out, // memory address
    output logic primary_select_n_out, // primary select, low active
    output logic secondary_select_out, // secondary select, high active
    output logic output_gate_n_out, // output gate, low active
    output logic write_strobe_n_out, // write strobe, low active
    output logic [sram_host_pkg::DATA_W-1:0] mem_dq_out, // data driven
    output logic mem_dq_oe_out, // data drive enable
    input wire logic [sram_host_pkg::DATA_W-1:0] mem_dq_in // data from pins
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_READ, ST_FLOAT, ST_RETAIN, ST_RECOVER
    } state_t;
    ////////////////////////////////////////////////////////////////
    logic rst_meta_reg, rst_sync_reg;
    logic [sram_host_pkg::DATA_W-1:0] dq_meta_reg, dq_sync_reg;
    logic retain_meta_reg, retain_sync_reg;
    state_t state_reg;
    logic [sram_host_pkg::CNT_W-1:0] cnt_reg;
    // reset release through two flops
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    // pin data and retention request are synchronised before use
    always_ff @(posedge ref_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            dq_meta_reg <= '0;
            dq_sync_reg <= '0;
            retain_meta_reg <= 1'b0;
            retain_sync_reg <= 1'b0;
        end else begin
            dq_meta_reg <= mem_dq_in;
            dq_sync_reg <= dq_meta_reg;
            retain_meta_reg <= retain_in;
            retain_sync_reg <= retain_meta_reg;
        end
    end
    function automatic logic [sram_host_pkg::CNT_W-1:0] cyc(input int n);
        return sram_host_pkg::CNT_W'(n - 1);
    endfunction
    ////////////////////////////////////////////////////////////////
    // sequencer: selects first, strobe last, so a write always runs on the strobe
    always_ff @(posedge ref_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (retain_sync_reg) begin
                        state_reg <= ST_RETAIN;
                    end else if (req_valid_in) begin
                        cnt_reg <= req_write_in ? cyc(SETUP_CYCLES) : cyc(ACCESS_CYCLES);
                        state_reg <= req_write_in ? ST_SETUP : ST_READ;
                    end
                end
                ST_SETUP: begin
                    if (cnt_reg == '0) begin
                        cnt_reg <= cyc(PULSE_CYCLES);
                        state_reg <= ST_PULSE;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ST_PULSE: begin
                    if (cnt_reg == '0) begin
                        cnt_reg <= cyc(HOLD_CYCLES);
                        state_reg <= ST_HOLD;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ST_HOLD: begin
                    // the float wait pads a write, so a held request cannot start the next one too soon
                    if (cnt_reg == '0) begin
                        cnt_reg <= cyc(FLOAT_CYCLES);
                        state_reg <= ST_FLOAT;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ST_READ: begin
                    if (cnt_reg == '0) begin
                        cnt_reg <= cyc(FLOAT_CYCLES);
                        state_reg <= ST_FLOAT;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ST_FLOAT: begin
                    // memory floats before the next cycle may drive
                    if (cnt_reg == '0) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ST_RETAIN: begin
                    if (!retain_sync_reg) begin
                        cnt_reg <= cyc(RECOVERY_CYCLES);
                        state_reg <= ST_RECOVER;
                    end
                end
                ST_RECOVER: begin
                    if (cnt_reg == '0) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////
    // pin drive; every pin a flop so no glitch reaches the memory
    always_ff @(posedge ref_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            mem_addr_out <= '0;
            primary_select_n_out <= 1'b1;
            secondary_select_out <= 1'b0;
            output_gate_n_out <= 1'b1;
            write_strobe_n_out <= 1'b1;
            mem_dq_out <= '0;
            mem_dq_oe_out <= 1'b0;
        end else begin
            if (state_reg == ST_IDLE && req_valid_in && !retain_sync_reg) begin
                mem_addr_out <= req_addr_in;
                mem_dq_out <= req_wdata_in;
            end
            // secondary select low and firm while retaining or idle
            secondary_select_out <= (state_reg == ST_IDLE && req_valid_in && !retain_sync_reg)
                || state_reg == ST_SETUP || state_reg == ST_PULSE || state_reg == ST_HOLD
                || state_reg == ST_READ;
            primary_select_n_out <= !((state_reg == ST_IDLE && req_valid_in && !retain_sync_reg)
                || state_reg == ST_SETUP || state_reg == ST_PULSE || state_reg == ST_HOLD
                || state_reg == ST_READ);
            // strobe low only inside the select window
            write_strobe_n_out <= !((state_reg == ST_SETUP && cnt_reg == '0)
                || (state_reg == ST_PULSE && cnt_reg != '0));
            // gate held high in writes, so the memory never drives against us
            output_gate_n_out <= !((state_reg == ST_IDLE && req_valid_in && !req_write_in
                && !retain_sync_reg) || (state_reg == ST_READ && cnt_reg != '0));
            mem_dq_oe_out <= (state_reg == ST_IDLE && req_valid_in && req_write_in && !retain_sync_reg)
                || state_reg == ST_SETUP || state_reg == ST_PULSE;
        end
    end
    ////////////////////////////////////////////////////////////////
    // user-side status and read capture
    always_ff @(posedge ref_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            req_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= '0;
            retained_out <= 1'b0;
        end else begin
            req_ready_out <= state_reg == ST_IDLE && !req_valid_in && !retain_sync_reg;
            rsp_valid_out <= (state_reg == ST_HOLD || state_reg == ST_READ) && cnt_reg == '0;
            if (state_reg == ST_READ && cnt_reg == '0) begin
                rsp_rdata_out <= dq_sync_reg;
            end
            retained_out <= state_reg == ST_RETAIN;
        end
    end
    ////////////////////////////////////////////////////////////////
    property p_strobe_qualified;
        @(posedge ref_clk_in) disable iff (!rst_sync_reg)
        !write_strobe_n_out |-> !primary_select_n_out && secondary_select_out;
    endproperty
    a_strobe_qualified: assert property (p_strobe_qualified) else $error("strobe low outside select");
    property p_pulse_width;
        @(posedge ref_clk_in) disable iff (!rst_sync_reg)
        $fell(write_strobe_n_out) |-> !write_strobe_n_out [*8];
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("write pulse too short");
    property p_no_contention;
        @(posedge ref_clk_in) disable iff (!rst_sync_reg)
        mem_dq_oe_out |-> output_gate_n_out;
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("drive with gate low");
    property p_addr_hold;
        @(posedge ref_clk_in) disable iff (!rst_sync_reg)
        $rose(write_strobe_n_out) |-> $stable(mem_addr_out) && !primary_select_n_out;
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved at write finish");
    property p_data_at_finish;
        @(posedge ref_clk_in) disable iff (!rst_sync_reg)
        $rose(write_strobe_n_out) |-> $past(mem_dq_oe_out) && $stable(mem_dq_out);
    endproperty
    a_data_at_finish: assert property (p_data_at_finish) else $error("data not held to finish");
    property p_retain_deselected;
        @(posedge ref_clk_in) disable iff (!rst_sync_reg)
        retained_out |-> !secondary_select_out && primary_select_n_out;
    endproperty
    a_retain_deselected: assert property (p_retain_deselected) else $error("selected in retention");
    sequence s_retain_exit;
        $fell(retained_out);
    endsequence
    property p_recovery;
        @(posedge ref_clk_in) disable iff (!rst_sync_reg)
        s_retain_exit |-> primary_select_n_out [*8];
    endproperty
    a_recovery: assert property (p_recovery) else $error("access too soon after retention");
    property p_strobe_after_select;
        @(posedge ref_clk_in) disable iff (!rst_sync_reg)
        $fell(write_strobe_n_out) |-> $past(!primary_select_n_out);
    endproperty
    a_strobe_after_select: assert property (p_strobe_after_select) else $error("strobe before select");
endmodule // sram_host
`default_nettype wire

// >>> testbench/sram_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side memory: stores on write close, drives reads late, counts host timing slips
module sram_model #(
    parameter int ACCESS_NS = 100,
    parameter int TURN_ON_NS = 10
) (
    input wire sram_host_pkg::pins_t pins_in, // address and controls
    input wire logic [7:0] host_dq_in, // host data
    input wire logic host_oe_in, // host drives data
    output logic [7:0] bus_out, // resolved data wire
    output int viol_out // host slips seen
);
    logic [7:0] mem [8192];
    logic [7:0] old_q;
    realtime t_sel = -1000.0, t_on = 0.0, t_acc = 0.0, t_ws = -1000.0, t_we = -1000.0;
    realtime t_a = 0.0, t_d = 0.0, dt;
    wire sel = !pins_in.primary_select_n && pins_in.secondary_select;
    wire wr = sel && !pins_in.write_strobe_n;
    wire rd = sel && pins_in.write_strobe_n && !pins_in.output_gate_n;
    initial viol_out = 0;
    initial bus_out = 8'h00;
    ////////////////////////////////////////////////////////////////////////////
    // edge times of selection, address and data
    always @(posedge sel) t_sel = $realtime;
    always @(host_dq_in or host_oe_in) t_d = $realtime;
    always @(posedge rd) begin
        t_on = $realtime;
        t_acc = $realtime;
    end
    // an address may not move inside a write or just after it closes
    always @(pins_in.addr) begin
        old_q = bus_out;
        t_acc = $realtime;
        t_a = $realtime;
        if (wr === 1'b1 || $realtime - t_we < 5.0) viol_out++;
    end
    always @(posedge wr) begin
        if ($realtime - t_ws < 100.0) viol_out++;
        t_ws = $realtime;
    end
    // the word is stored where the write interval closes; start guard skips the power-up edge
    always @(negedge wr) if (t_ws > 0.0) begin
        if ($realtime - t_ws < 60.0 || $realtime - t_sel < 80.0) viol_out++;
        if ($realtime - t_d < 40.0 || $realtime - t_a < 80.0 || t_a > t_ws) viol_out++;
        t_we = $realtime;
        mem[pins_in.addr] = host_dq_in;
    end
    ////////////////////////////////////////////////////////////////////////////
    // float at once, turn on late, so release is always the quicker; a free wire toggles
    always #0.5 begin
        dt = $realtime - t_acc;
        if (host_oe_in === 1'b1) bus_out = host_dq_in;
        else if (rd && $realtime - t_on >= TURN_ON_NS)
            bus_out = (dt < 10.0) ? old_q : (dt >= ACCESS_NS) ? mem[pins_in.addr] : ~mem[pins_in.addr];
        else bus_out = ~bus_out;
        if (host_oe_in === 1'b1 && rd && $realtime - t_on >= TURN_ON_NS) viol_out++;
    end
endmodule // sram_model
`default_nettype wire

// >>> testbench/sram_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sram_host_tb;
    logic ref_clk_in = 1'b0, reset_n_in = 1'b0, req_valid_in = 1'b0, req_write_in = 1'b0, retain_in = 1'b0;
    logic [12:0] req_addr_in = 13'h0000, mem_addr_out, a;
    logic [7:0] req_wdata_in = 8'h00, rsp_rdata_out, mem_dq_out, bus;
    logic req_ready_out, rsp_valid_out, retained_out, mem_dq_oe_out;
    logic primary_select_n_out, secondary_select_out, output_gate_n_out, write_strobe_n_out;
    logic [7:0] shadow [8192];
    logic [8:0] notes [$];
    logic [8:0] note;
    int n_errors = 0, num_checks = 0, viol, n;
    sram_host_pkg::pins_t pins;
    assign pins = {mem_addr_out, primary_select_n_out, secondary_select_out, output_gate_n_out, write_strobe_n_out};
    sram_host i_dut (.ref_clk_in, .reset_n_in, .req_valid_in, .req_write_in, .req_addr_in, .req_wdata_in,
        .retain_in, .req_ready_out, .rsp_valid_out, .rsp_rdata_out, .retained_out, .mem_addr_out,
        .primary_select_n_out, .secondary_select_out, .output_gate_n_out, .write_strobe_n_out,
        .mem_dq_out, .mem_dq_oe_out, .mem_dq_in(bus));
    // answers right at the access limit, so the capture margin is the design's own
    sram_model #(.ACCESS_NS(100), .TURN_ON_NS(10)) i_mem (.pins_in(pins), .host_dq_in(mem_dq_out),
        .host_oe_in(mem_dq_oe_out), .bus_out(bus), .viol_out(viol));
    initial forever #2.5 ref_clk_in = ~ref_clk_in;
    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        cmp_byte(what, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // wait for idle under a bound, so a stuck controller cannot hang the run
    task automatic wait_idle();
        n = 0;
        while ((req_ready_out !== 1'b1 || notes.size() != 0) && n < 400) begin
            @(negedge ref_clk_in);
            n++;
        end
        cmp_bit("idle reached", 1'b1, req_ready_out);
        cmp_bit("responses drained", 1'b1, notes.size() == 0);
    endtask
    // one request, presented while idle and dropped once taken; the expected answer is noted
    task automatic req(input logic w, input logic [12:0] ad, input logic [7:0] d);
        n = 0;
        @(negedge ref_clk_in);
        while (req_ready_out !== 1'b1 && n < 400) begin
            @(negedge ref_clk_in);
            n++;
        end
        req_valid_in = 1'b1;
        req_write_in = w;
        req_addr_in = ad;
        req_wdata_in = d;
        @(negedge ref_clk_in);
        req_valid_in = 1'b0;
        cmp_bit("taken", 1'b0, req_ready_out);
        if (w) shadow[ad] = d;
        notes.push_back({~w, shadow[ad]});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // each completion pulse consumes the oldest note; reads compare the data
    always @(negedge ref_clk_in) if (rsp_valid_out === 1'b1) begin
        if (notes.size() == 0) cmp_bit("spare response", 1'b0, 1'b1);
        else begin
            note = notes.pop_front();
            if (note[8]) cmp_byte("read data", note[7:0], rsp_rdata_out);
        end
    end
    // hang guard, far beyond the roughly 1300 cycles the sequence needs
    initial begin
        #100000;
        n_errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h565d1a35));
        repeat (3) @(negedge ref_clk_in);
        cmp_bit("primary in reset", 1'b1, primary_select_n_out);
        cmp_bit("secondary in reset", 1'b0, secondary_select_out);
        cmp_bit("strobe in reset", 1'b1, write_strobe_n_out);
        cmp_bit("drive in reset", 1'b0, mem_dq_oe_out);
        cmp_bit("gate in reset", 1'b1, output_gate_n_out);
        repeat (3) @(negedge ref_clk_in);
        reset_n_in = 1'b1;
        // boundary words, then random ones, each read straight back
        for (int i = 0; i < 12; i++) begin
            a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1FFF : 13'($urandom);
            req(1'b1, a, 8'($urandom));
            req(1'b0, a, 8'h00);
        end
        // back-to-back writes, then reads in reverse order
        a = 13'($urandom);
        for (int i = 0; i < 8; i++) req(1'b1, a + 13'(i), 8'($urandom));
        for (int i = 7; i >= 0; i--) req(1'b0, a + 13'(i), 8'h00);
        // a request while busy is dropped, not queued
        req(1'b1, 13'h0ABC, 8'hA5);
        @(negedge ref_clk_in);
        req_valid_in = 1'b1;
        req_wdata_in = 8'h5A;
        repeat (4) @(negedge ref_clk_in);
        req_valid_in = 1'b0;
        req(1'b0, 13'h0ABC, 8'h00);
        wait_idle();
        // retention: deselect, refuse work, then wait a full read cycle before the next access
        // the request waits until retention has passed the synchroniser, else it would be taken first
        retain_in = 1'b1;
        repeat (4) @(negedge ref_clk_in);
        req_valid_in = 1'b1;
        repeat (6) @(negedge ref_clk_in);
        cmp_bit("retained", 1'b1, retained_out);
        cmp_bit("primary in retention", 1'b1, primary_select_n_out);
        cmp_bit("secondary in retention", 1'b0, secondary_select_out);
        cmp_bit("ready in retention", 1'b0, req_ready_out);
        req_valid_in = 1'b0;
        retain_in = 1'b0;
        n = 0;
        while (req_ready_out !== 1'b1 && n < 400) begin
            @(negedge ref_clk_in);
            n++;
        end
        cmp_bit("recovery wait", 1'b1, n >= 20 && n < 400);
        req(1'b0, 13'h0ABC, 8'h00);
        wait_idle();
        cmp_bit("host timing clean", 1'b1, viol == 0);
        print_verdict();
    end
endmodule // sram_host_tb
`default_nettype wire
